// >>> bus_pin_cfg.svh
// Constants for the bus and peripheral pin-state controller
// ==========================================================================
// Functional notes
// - Matching first-three chip select low, others high
// - External strobes and data lanes follow access size
// - On-chip access: strobes high, address out, data floats
// - Row strobe low only in row-down or refresh
// - Column strobes low only during refresh
// - Power-on reset and sleep fixed pin levels
// - Standby footnoted outputs float when float bit set
// - Port inputs float, outputs keep mode and level; code floats them in standby with float bit set
// - Standby float bit six: one floats, zero holds
`ifndef BUS_PIN_CFG_SVH
`define BUS_PIN_CFG_SVH

// ==========================================================================
// Widths
`define BPS_ADDR_W        22
`define BPS_DATA_W        16
`define BPS_CS_COUNT      4
`define BPS_CS_DECODED    3
`define BPS_PORT_W        16
`define BPS_PERIPH_W      8

// ==========================================================================
// Standby control bit position that floats the pins in standby
`define BPS_STANDBY_FLOAT_POS 6

// ==========================================================================
// Pin values shown during power-on reset
`define BPS_RST_CS_N      4'hf
`define BPS_RST_CS_OE     4'h3
`define BPS_RST_ADDR      22'h000000
`define BPS_RST_DATA      16'h0000

`endif

// >>> bus_pin_pkg.sv
// Types shared by the bus pin-state controller and its pin groups
`include "bus_pin_cfg.svh"

package bus_pin_pkg;

  // ========================================================================
  // Power state of the device; power-on reset is the reset itself
  typedef enum logic [1:0]
  {
    PWR_RUN     = 2'b00,
    PWR_SLEEP   = 2'b01,
    PWR_STANDBY = 2'b10
  } power_mode_t;

  // ========================================================================
  // Kind and size of the current bus access
  typedef enum logic [1:0]
  {
    ACC_IDLE     = 2'b00,
    ACC_ONCHIP   = 2'b01,
    ACC_EXTERNAL = 2'b10
  } access_kind_t;

  typedef enum logic [1:0]
  {
    SZ_BYTE8 = 2'b00,
    SZ_UPPER = 2'b01,
    SZ_LOWER = 2'b10,
    SZ_WORD  = 2'b11
  } access_size_t;

  // ========================================================================
  // Access request from the bus state controller
  typedef struct packed
  {
    access_kind_t                kind;
    access_size_t                size;
    logic                        write;
    logic [1:0]                  area;
    logic [`BPS_ADDR_W-1:0]      addr;
    logic [`BPS_DATA_W-1:0]      wdata;
  } bus_request_t;

  // ========================================================================
  // Bus pin drive: every pin as value plus output enable (high = driving)
  typedef struct packed
  {
    logic [`BPS_CS_COUNT-1:0]    chipSelectN;
    logic [`BPS_CS_COUNT-1:0]    chipSelectOe;
    logic                        rowStrobeN;
    logic                        upperColumnStrobeN;
    logic                        lowerColumnStrobeN;
    logic                        busDirectionLine;
    logic                        dramCtlOe;
    logic                        addressHoldN;
    logic                        addressHoldOe;
    logic                        readStrobeN;
    logic                        readStrobeOe;
    logic                        upperWriteStrobeN;
    logic                        lowerWriteStrobeN;
    logic                        writeStrobeOe;
    logic [`BPS_ADDR_W-1:0]      addr;
    logic                        addrOe;
    logic [`BPS_DATA_W-1:0]      data;
    logic                        dataOeUpper;
    logic                        dataOeLower;
  } bus_pins_t;

endpackage : bus_pin_pkg

// >>> bus_pin_state_control.sv
// Pin-state controller for the external bus, peripheral outputs and port pins
`timescale 1ns/100ps
`default_nettype none
`include "bus_pin_cfg.svh"

module bus_pin_state_control
(
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  // Power state and standby control
  input  wire bus_pin_pkg::power_mode_t       powerMode,
  input  wire logic [7:0]                     standbyControl,
  // Bus access from the bus state controller
  input  wire bus_pin_pkg::bus_request_t      busRequest,
  input  wire logic                           rowDownState,
  input  wire logic                           refreshActive,
  // Clock and watchdog pins
  input  wire logic                           watchdogOverflow,
  // Footnoted peripheral outputs: acknowledges, transmit, timer
  input  wire logic [`BPS_PERIPH_W-1:0]       periphIsOutput,
  input  wire logic [`BPS_PERIPH_W-1:0]       periphLevel,
  // General-purpose port pins
  input  wire logic [`BPS_PORT_W-1:0]         portIsOutput,
  input  wire logic [`BPS_PORT_W-1:0]         portLevel,
  // Bus pin drive
  output bus_pin_pkg::bus_pins_t              busPins,
  // Clock pin: enable, and force-high over the running clock
  output logic                                clockOutOe,
  output logic                                clockForceHigh,
  output logic                                watchdogOverflowOut,
  // Peripheral and port pin drive
  output logic [`BPS_PERIPH_W-1:0]            periphOe,
  output logic [`BPS_PERIPH_W-1:0]            periphOut,
  output logic [`BPS_PORT_W-1:0]              portOe,
  output logic [`BPS_PORT_W-1:0]              portOut
);

  // ========================================================================
  // State
  typedef struct packed
  {
    bus_pin_pkg::bus_pins_t pins;
    logic                   clkOe;
    logic                   clkHigh;
    logic                   wdtOut;
  } ctl_state_t;

  ctl_state_t stateFf;
  ctl_state_t nxtState;

  logic standbyFloatBit;
  logic isExternal;
  logic isWrite;
  logic laneUpper;
  logic laneLower;

  assign standbyFloatBit = standbyControl[`BPS_STANDBY_FLOAT_POS];
  assign isExternal      = (busRequest.kind == bus_pin_pkg::ACC_EXTERNAL);
  assign isWrite         = busRequest.write;

  // Data lanes used by the access size; 8-bit space sits on the lower lane
  assign laneUpper = (busRequest.size == bus_pin_pkg::SZ_UPPER) ||
                     (busRequest.size == bus_pin_pkg::SZ_WORD);
  assign laneLower = (busRequest.size != bus_pin_pkg::SZ_UPPER);

  // ========================================================================
  // Next pin state from power state and current access.
  // Everything is registered so a state change never glitches a strobe,
  // at the cost of one cycle from request to pin.
  always_comb
  begin
    nxtState = stateFf;
    // Defaults: idle bus, every strobe inactive and driven
    nxtState.pins.chipSelectN        = '1;
    nxtState.pins.chipSelectOe       = '1;
    nxtState.pins.rowStrobeN         = 1'b1;
    nxtState.pins.upperColumnStrobeN = 1'b1;
    nxtState.pins.lowerColumnStrobeN = 1'b1;
    nxtState.pins.busDirectionLine   = 1'b1;
    nxtState.pins.dramCtlOe          = 1'b1;
    nxtState.pins.addressHoldN       = 1'b0;
    nxtState.pins.addressHoldOe      = 1'b1;
    nxtState.pins.readStrobeN        = 1'b1;
    nxtState.pins.readStrobeOe       = 1'b1;
    nxtState.pins.upperWriteStrobeN  = 1'b1;
    nxtState.pins.lowerWriteStrobeN  = 1'b1;
    nxtState.pins.writeStrobeOe      = 1'b1;
    nxtState.pins.addrOe             = 1'b1;
    nxtState.pins.dataOeUpper        = 1'b0;
    nxtState.pins.dataOeLower        = 1'b0;
    nxtState.clkOe                   = 1'b1;
    nxtState.clkHigh                 = 1'b0;
    nxtState.wdtOut                  = watchdogOverflow;
    unique case (powerMode)
      bus_pin_pkg::PWR_RUN:
      begin
        // Idle and on-chip accesses keep the defaults; address still shown
        nxtState.pins.addr = busRequest.addr;
        if (isExternal)
        begin
          // Only three selects decode an area; the fourth stays high
          for (int i = 0; i < `BPS_CS_DECODED; i++)
          begin
            nxtState.pins.chipSelectN[i] = (busRequest.area != 2'(i));
          end
          nxtState.pins.readStrobeN       = isWrite;
          nxtState.pins.upperWriteStrobeN = !(isWrite && laneUpper);
          nxtState.pins.lowerWriteStrobeN = !(isWrite && laneLower);
          nxtState.pins.dataOeUpper       = isWrite && laneUpper;
          nxtState.pins.dataOeLower       = isWrite && laneLower;
          nxtState.pins.data              = busRequest.wdata;
        end
        // Row strobe follows the memory controller, column strobes refresh only
        nxtState.pins.rowStrobeN         = !(rowDownState || refreshActive);
        nxtState.pins.upperColumnStrobeN = !refreshActive;
        nxtState.pins.lowerColumnStrobeN = !refreshActive;
      end
      bus_pin_pkg::PWR_SLEEP:
      begin
        // No bus traffic: strobes high, address hold low, last address held
        // Address is not among the defaults, so it keeps its last value
        nxtState.pins.addressHoldN = 1'b0;
      end
      bus_pin_pkg::PWR_STANDBY:
      begin
        // Bus released; the memory control lines stay driven high
        // dramCtlOe keeps its default, so those lines float only in reset
        nxtState.pins.chipSelectOe  = '0;
        nxtState.pins.addressHoldOe = 1'b0;
        nxtState.pins.readStrobeOe  = 1'b0;
        nxtState.pins.writeStrobeOe = 1'b0;
        nxtState.pins.addrOe        = 1'b0;
        nxtState.clkHigh            = 1'b1;
        nxtState.clkOe              = !standbyFloatBit;
      end
      default:
      begin
        // Unused power code: behave as sleep, the safest bus state
        nxtState.pins.addressHoldN = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Register; reset values are the power-on reset pin levels
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stateFf                         <= '0;
      stateFf.pins.chipSelectN        <= `BPS_RST_CS_N;
      stateFf.pins.chipSelectOe       <= `BPS_RST_CS_OE;
      stateFf.pins.rowStrobeN         <= 1'b1;
      stateFf.pins.upperColumnStrobeN <= 1'b1;
      stateFf.pins.lowerColumnStrobeN <= 1'b1;
      stateFf.pins.busDirectionLine   <= 1'b1;
      stateFf.pins.dramCtlOe          <= 1'b0;
      stateFf.pins.addressHoldN       <= 1'b1;
      stateFf.pins.addressHoldOe      <= 1'b0;
      stateFf.pins.readStrobeN        <= 1'b1;
      stateFf.pins.readStrobeOe       <= 1'b1;
      stateFf.pins.upperWriteStrobeN  <= 1'b1;
      stateFf.pins.lowerWriteStrobeN  <= 1'b1;
      stateFf.pins.writeStrobeOe      <= 1'b1;
      stateFf.pins.addr               <= `BPS_RST_ADDR;
      stateFf.pins.addrOe             <= 1'b1;
      stateFf.pins.data               <= `BPS_RST_DATA;
      // Clock pin drives through reset; only standby may release it
      stateFf.clkOe                   <= 1'b1;
    end
    else
    begin
      stateFf <= nxtState;
    end
  end

  assign busPins             = stateFf.pins;
  assign clockOutOe          = stateFf.clkOe;
  assign clockForceHigh      = stateFf.clkHigh;
  assign watchdogOverflowOut = stateFf.wdtOut;

  // ========================================================================
  // Footnoted peripheral outputs keep working in sleep
  pin_hold_group
  #(
    .WIDTH         (`BPS_PERIPH_W),
    .HOLD_IN_SLEEP (1'b0)
  )
  u_periph_pins
  (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .powerMode       (powerMode),
    .standbyFloatBit (standbyFloatBit),
    .pinIsOutput     (periphIsOutput),
    .pinLevel        (periphLevel),
    .pinOe           (periphOe),
    .pinOut          (periphOut)
  );

  // Port pins freeze direction and level in sleep, and in standby unless the float bit is set
  // Frozen direction keeps an input from turning into an output
  pin_hold_group
  #(
    .WIDTH         (`BPS_PORT_W),
    .HOLD_IN_SLEEP (1'b1)
  )
  u_port_pins
  (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .powerMode       (powerMode),
    .standbyFloatBit (standbyFloatBit),
    .pinIsOutput     (portIsOutput),
    .pinLevel        (portLevel),
    .pinOe           (portOe),
    .pinOut          (portOut)
  );

endmodule : bus_pin_state_control
`default_nettype wire

// >>> bus_pin_state_control_sva.sv
// Concurrent checks on the pin-state controller ports
`timescale 1ns/100ps
`default_nettype none
`include "bus_pin_cfg.svh"

module bus_pin_state_control_sva
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // Inputs watched
  input  wire bus_pin_pkg::power_mode_t   powerMode,
  input  wire logic [7:0]                 standbyControl,
  input  wire bus_pin_pkg::bus_request_t  busRequest,
  input  wire logic                       rowDownState,
  input  wire logic                       refreshActive,
  // Outputs watched
  input  wire bus_pin_pkg::bus_pins_t     busPins,
  input  wire logic                       clockOutOe,
  input  wire logic                       clockForceHigh,
  input  wire logic [`BPS_PERIPH_W-1:0]   periphOe,
  input  wire logic [`BPS_PORT_W-1:0]     portOe,
  input  wire logic [`BPS_PORT_W-1:0]     portOut
);
  logic                       live_ff;
  bus_pin_pkg::bus_request_t  prevReq_ff;
  bus_pin_pkg::power_mode_t   prevMode_ff;
  logic                       prevRow_ff;
  logic                       prevRef_ff;
  logic                       prevFloat_ff;

  // =========================================================================
  // Helpers: last edge inputs; live hides the edge that still shows reset state
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) live_ff <= 1'b0;
    else live_ff <= 1'b1;
  always_ff @(posedge sys_clk)
  begin
    prevReq_ff   <= busRequest;
    prevMode_ff  <= powerMode;
    prevRow_ff   <= rowDownState;
    prevRef_ff   <= refreshActive;
    prevFloat_ff <= standbyControl[`BPS_STANDBY_FLOAT_POS];
  end
  wire logic run1 = live_ff && prevMode_ff == bus_pin_pkg::PWR_RUN;
  wire logic ext1 = run1 && prevReq_ff.kind == bus_pin_pkg::ACC_EXTERNAL;
  wire logic wr1  = ext1 && prevReq_ff.write;
  wire logic up1  = prevReq_ff.size inside {bus_pin_pkg::SZ_UPPER, bus_pin_pkg::SZ_WORD};
  wire logic lo1  = prevReq_ff.size != bus_pin_pkg::SZ_UPPER;
  wire logic slp1 = live_ff && prevMode_ff == bus_pin_pkg::PWR_SLEEP;
  wire logic stb1 = live_ff && prevMode_ff == bus_pin_pkg::PWR_STANDBY;

  // =========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_cs_match: assert property (ext1 && prevReq_ff.area != 2'h3 |->
    busPins.chipSelectN == ~(4'h1 << prevReq_ff.area)) else $error("chip select not matching area");
  a_cs_none: assert property (run1 && !(ext1 && prevReq_ff.area != 2'h3) |-> busPins.chipSelectN == 4'hf)
    else $error("chip select low without external area");
  a_read_lanes: assert property (ext1 && !prevReq_ff.write |-> !busPins.readStrobeN && busPins.upperWriteStrobeN
    && busPins.lowerWriteStrobeN && !busPins.dataOeUpper && !busPins.dataOeLower) else $error("read strobes wrong");
  a_write_lanes: assert property (wr1 |-> busPins.readStrobeN && busPins.upperWriteStrobeN == !up1
    && busPins.lowerWriteStrobeN == !lo1 && busPins.dataOeUpper == up1 && busPins.dataOeLower == lo1)
    else $error("write strobes or lanes wrong");
  a_onchip_quiet: assert property (run1 && prevReq_ff.kind == bus_pin_pkg::ACC_ONCHIP |->
    busPins.chipSelectN == 4'hf && busPins.readStrobeN && busPins.upperWriteStrobeN && busPins.lowerWriteStrobeN
    && busPins.busDirectionLine && !busPins.addressHoldN && busPins.addr == prevReq_ff.addr
    && !busPins.dataOeUpper && !busPins.dataOeLower) else $error("on-chip access pins wrong");
  a_row_strobe: assert property (run1 |-> busPins.rowStrobeN == !(prevRow_ff || prevRef_ff))
    else $error("row strobe wrong");
  a_col_strobe: assert property (run1 |-> busPins.upperColumnStrobeN == !prevRef_ff
    && busPins.lowerColumnStrobeN == !prevRef_ff) else $error("column strobes wrong");
  a_reset_levels: assert property (!live_ff |-> busPins.chipSelectN == `BPS_RST_CS_N
    && busPins.chipSelectOe == `BPS_RST_CS_OE && busPins.readStrobeN && busPins.addr == `BPS_RST_ADDR
    && !busPins.dataOeUpper && !busPins.dataOeLower && !busPins.addressHoldOe) else $error("reset levels wrong");
  a_sleep_levels: assert property (slp1 |-> busPins.readStrobeN && busPins.upperWriteStrobeN
    && busPins.lowerWriteStrobeN && busPins.chipSelectN == 4'hf && !busPins.addressHoldN)
    else $error("sleep levels wrong");
  a_standby_float: assert property (stb1 && prevFloat_ff |-> !clockOutOe && periphOe == 8'h00
    && portOe == 16'h0000) else $error("standby pins not floating");
  a_standby_hold: assert property (stb1 && !prevFloat_ff |-> clockForceHigh)
    else $error("clock not held in standby");
  a_port_hold: assert property (slp1 && $past(slp1) |-> $stable(portOe) && $stable(portOut))
    else $error("port pins changed in sleep");
  c_ext_write: cover property (wr1 && up1 && lo1);
  c_float: cover property (stb1 && prevFloat_ff);
  c_sleep: cover property (slp1 && $past(slp1));
endmodule : bus_pin_state_control_sva
`default_nettype wire

// >>> ext_bus_memory.sv
// External memory model on the normal bus space
`timescale 1ns/100ps
`default_nettype none
`include "bus_pin_cfg.svh"

module ext_bus_memory
(
  // Clock
  input  wire logic                   sys_clk,
  // Bus pins from the device
  input  wire bus_pin_pkg::bus_pins_t busPins,
  // Last stored word and the select pattern it came with
  output logic [`BPS_DATA_W-1:0]      lastWord,
  output logic [3:0]                  lastSelect
);
  logic [`BPS_DATA_W-1:0] dataBus;

  initial lastWord = 16'h0000;
  // Released lanes show the inverse of the last word so a stale value never matches
  assign dataBus = {busPins.dataOeUpper ? busPins.data[15:8] : ~lastWord[15:8],
                    busPins.dataOeLower ? busPins.data[7:0] : ~lastWord[7:0]};

  // Store the strobed lanes while any chip select is low
  always @(posedge sys_clk)
    if (busPins.chipSelectN != 4'hf && !(busPins.upperWriteStrobeN && busPins.lowerWriteStrobeN))
    begin
      if (!busPins.upperWriteStrobeN) lastWord[15:8] <= dataBus[15:8];
      if (!busPins.lowerWriteStrobeN) lastWord[7:0] <= dataBus[7:0];
      lastSelect <= busPins.chipSelectN;
    end
endmodule : ext_bus_memory
`default_nettype wire

// >>> pin_hold_group.sv
// Group of output-capable pins that hold or float in the power-down states
`timescale 1ns/100ps
`default_nettype none
`include "bus_pin_cfg.svh"

module pin_hold_group
#(
  parameter int WIDTH         = 8,
  parameter bit HOLD_IN_SLEEP = 1'b0
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Power state
  input  wire bus_pin_pkg::power_mode_t powerMode,
  input  wire logic              standbyFloatBit,
  // Pin source: direction (1 = output) and level
  input  wire logic [WIDTH-1:0]  pinIsOutput,
  input  wire logic [WIDTH-1:0]  pinLevel,
  // Pin drive
  output logic      [WIDTH-1:0]  pinOe,
  output logic      [WIDTH-1:0]  pinOut
);

  // ========================================================================
  // State
  typedef struct packed
  {
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] out;
  } group_state_t;

  group_state_t stateFf;
  group_state_t nxtState;

  logic holdLevel;
  logic floatAll;

  // Level is frozen in standby, and in sleep where the group asks for it;
  // spare code 11 shares bit 0 with sleep and is held the same way
  assign holdLevel = (powerMode == bus_pin_pkg::PWR_STANDBY) ||
                     (HOLD_IN_SLEEP && powerMode[0]);
  assign floatAll  = (powerMode == bus_pin_pkg::PWR_STANDBY) && standbyFloatBit;

  // Per-pin selection; direction is frozen with the level so a mode never flips
  always_comb
  begin
    nxtState = stateFf;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (floatAll)
      begin
        nxtState.oe[i] = 1'b0;
      end
      else if (holdLevel)
      begin
        nxtState.oe[i] = stateFf.oe[i];
      end
      else
      begin
        nxtState.oe[i]  = pinIsOutput[i];
        nxtState.out[i] = pinLevel[i];
      end
    end
  end

  // Register; reset floats every pin in the group
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stateFf <= '0;
    end
    else
    begin
      stateFf <= nxtState;
    end
  end

  assign pinOe  = stateFf.oe;
  assign pinOut = stateFf.out;

endmodule : pin_hold_group
`default_nettype wire

// >>> tb_bus_pin_state_control.sv
// Self-checking bench for the pin-state controller
`timescale 1ns/100ps
`default_nettype none
`include "bus_pin_cfg.svh"

module tb_bus_pin_state_control;
  logic sys_clk = 1'b0;
  logic resetn  = 1'b0;
  bus_pin_pkg::power_mode_t  powerMode;
  bus_pin_pkg::bus_request_t busRequest;
  bus_pin_pkg::bus_pins_t    busPins;
  logic [7:0]  standbyControl;
  logic [7:0]  periphIsOutput, periphLevel, periphOe, periphOut;
  logic [15:0] portIsOutput, portLevel, portOe, portOut, prevOe, lastWord;
  logic [3:0]  lastSelect;
  logic rowDownState, refreshActive, watchdogOverflow, watchdogOverflowOut, clockOutOe, clockForceHigh;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #20 sys_clk = ~sys_clk;

  bus_pin_state_control dut_u (.sys_clk(sys_clk), .resetn(resetn), .powerMode(powerMode),
    .standbyControl(standbyControl), .busRequest(busRequest), .rowDownState(rowDownState),
    .refreshActive(refreshActive), .watchdogOverflow(watchdogOverflow), .periphIsOutput(periphIsOutput),
    .periphLevel(periphLevel), .portIsOutput(portIsOutput), .portLevel(portLevel), .busPins(busPins),
    .clockOutOe(clockOutOe), .clockForceHigh(clockForceHigh), .watchdogOverflowOut(watchdogOverflowOut),
    .periphOe(periphOe), .periphOut(periphOut), .portOe(portOe), .portOut(portOut));
  ext_bus_memory mem_u (.sys_clk(sys_clk), .busPins(busPins), .lastWord(lastWord), .lastSelect(lastSelect));

  // =========================================================================
  // Reporting
  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // A hang still ends in the one closing report
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_of_test();
    end
  end

  // =========================================================================
  // Expectations: select, row, columns, read, writes, lane enables
  function automatic logic [11:0] expView(bus_pin_pkg::bus_request_t r, logic row, logic rf);
    logic [3:0] cs;
    logic ext, wr, up, lo;
    ext = r.kind == bus_pin_pkg::ACC_EXTERNAL;
    wr  = ext && r.write;
    up  = wr && r.size inside {bus_pin_pkg::SZ_UPPER, bus_pin_pkg::SZ_WORD};
    lo  = wr && r.size != bus_pin_pkg::SZ_UPPER;
    cs  = 4'hf;
    if (ext && r.area != 2'h3) cs[r.area] = 1'b0;
    return {cs, !(row || rf), !rf, !rf, !(ext && !r.write), !up, !lo, up, lo};
  endfunction : expView

  function automatic logic [11:0] gotView(bus_pin_pkg::bus_pins_t p);
    return {p.chipSelectN, p.rowStrobeN, p.upperColumnStrobeN, p.lowerColumnStrobeN, p.readStrobeN,
            p.upperWriteStrobeN, p.lowerWriteStrobeN, p.dataOeUpper, p.dataOeLower};
  endfunction : gotView

  function automatic bus_pin_pkg::bus_request_t mk(logic [1:0] k, logic [1:0] s, logic w, logic [1:0] a);
    mk.kind  = bus_pin_pkg::access_kind_t'(k);
    mk.size  = bus_pin_pkg::access_size_t'(s);
    mk.write = w;
    mk.area  = a;
    mk.addr  = 22'($urandom);
    mk.wdata = 16'($urandom);
  endfunction : mk

  function automatic bus_pin_pkg::bus_request_t rndReq();
    return mk(2'($urandom_range(2)), 2'($urandom_range(3)), 1'($urandom_range(1)), 2'($urandom_range(3)));
  endfunction : rndReq

  // =========================================================================
  // One cycle: drive on the falling edge, look after the next rising edge
  task automatic step(bus_pin_pkg::power_mode_t pm, logic fl, bus_pin_pkg::bus_request_t rq);
    prevOe           = portOe;
    powerMode        = pm;
    standbyControl   = {1'b0, fl, 6'h00};
    busRequest       = rq;
    rowDownState     = 1'($urandom_range(1));
    refreshActive    = ($urandom_range(3) == 0);
    watchdogOverflow = 1'($urandom_range(1));
    periphIsOutput   = 8'($urandom);
    periphLevel      = 8'($urandom);
    portIsOutput     = 16'($urandom);
    portLevel        = 16'($urandom);
    @(negedge sys_clk);
  endtask : step

  task automatic runStep(bus_pin_pkg::bus_request_t rq);
    logic [15:0] mask;
    step(bus_pin_pkg::PWR_RUN, 1'b0, rq);
    mask = {{8{busPins.dataOeUpper}}, {8{busPins.dataOeLower}}};
    check("bus view", expView(rq, rowDownState, refreshActive), gotView(busPins));
    if (rq.kind != bus_pin_pkg::ACC_IDLE) check("address", rq.addr, busPins.addr);
    if (rq.kind == bus_pin_pkg::ACC_EXTERNAL && rq.write) check("data", rq.wdata & mask, busPins.data & mask);
    check("input port oe", 16'h0000, portOe & ~portIsOutput);
    check("watchdog", watchdogOverflow, watchdogOverflowOut);
    check("port pins", {portIsOutput, portLevel}, {portOe, portOut});
    check("periph pins", {periphIsOutput, periphLevel}, {periphOe, periphOut});
  endtask : runStep

  // =========================================================================
  // Main sequence
  initial
  begin
    bus_pin_pkg::bus_request_t rq;
    powerMode = bus_pin_pkg::PWR_RUN;
    busRequest = '0;
    {standbyControl, rowDownState, refreshActive, watchdogOverflow} = 11'h000;
    {periphIsOutput, periphLevel, portIsOutput, portLevel} = 48'h0;
    void'($urandom(32'ha98a));
    repeat (6) @(negedge sys_clk);
    check("reset select", `BPS_RST_CS_N, busPins.chipSelectN);
    check("reset select oe", `BPS_RST_CS_OE, busPins.chipSelectOe);
    resetn = 1'b1;
    // Word write to area 1, then idle and an on-chip write, then the memory must hold it
    rq = mk(2'h2, 2'h3, 1'b1, 2'h1);
    runStep(rq);
    runStep(mk(2'h0, 2'h0, 1'b0, 2'h0));
    runStep(mk(2'h1, 2'h0, 1'b1, 2'h0));
    check("memory word", rq.wdata, lastWord);
    check("memory select", 4'hd, lastSelect);
    repeat (400) runStep(rndReq());
    // Sleep: strobes high, port pins frozen
    repeat (3)
    begin
      step(bus_pin_pkg::PWR_SLEEP, 1'b0, mk(2'h2, 2'h3, 1'b1, 2'h0));
      check("sleep view", expView(mk(2'h0, 2'h0, 1'b0, 2'h0), 1'b0, 1'b0), gotView(busPins));
      check("sleep hold", 1'b0, busPins.addressHoldN);
      check("sleep periph", {periphIsOutput, periphLevel}, {periphOe, periphOut});
    end
    check("sleep port", prevOe, portOe);
    // Spare power code behaves as sleep
    step(bus_pin_pkg::power_mode_t'(2'h3), 1'b0, rndReq());
    check("spare mode view", expView(mk(2'h0, 2'h0, 1'b0, 2'h0), 1'b0, 1'b0), gotView(busPins));
    check("spare mode port", prevOe, portOe);
    // Standby with the float bit clear holds, with it set floats
    repeat (3) step(bus_pin_pkg::PWR_STANDBY, 1'b0, mk(2'h2, 2'h0, 1'b1, 2'h2));
    check("standby port", prevOe, portOe);
    check("clock high", 2'h3, {clockOutOe, clockForceHigh});
    repeat (2) step(bus_pin_pkg::PWR_STANDBY, 1'b1, mk(2'h2, 2'h0, 1'b1, 2'h2));
    check("float pins", 25'h0, {clockOutOe, periphOe, portOe});
    check("float bus", 11'h200, {busPins.addrOe, busPins.dramCtlOe, busPins.chipSelectOe, busPins.readStrobeOe,
      busPins.writeStrobeOe, busPins.addressHoldOe, busPins.dataOeUpper, busPins.dataOeLower});
    // Reset in mid-run, then back to traffic
    runStep(mk(2'h2, 2'h1, 1'b1, 2'h0));
    resetn = 1'b0;
    #1;
    check("mid reset select", `BPS_RST_CS_N, busPins.chipSelectN);
    check("mid reset pin oe", 24'h0, {periphOe, portOe});
    @(negedge sys_clk);
    resetn = 1'b1;
    repeat (20) runStep(rndReq());
    end_of_test();
  end
endmodule : tb_bus_pin_state_control

bind bus_pin_state_control bus_pin_state_control_sva chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .powerMode(powerMode), .standbyControl(standbyControl), .busRequest(busRequest), .rowDownState(rowDownState),
  .refreshActive(refreshActive), .busPins(busPins), .clockOutOe(clockOutOe), .clockForceHigh(clockForceHigh),
  .periphOe(periphOe), .portOe(portOe), .portOut(portOut));
`default_nettype wire
